/* rtl/flow_ctrl.sv */
// Control-flow and mode instruction execution unit
// Behaviour
// - Indirect jump uses R4[5:0] and R3
// - Interrupt return pops frame, clears service
// - Interrupt return takes documented cycle count
// - No nested fast interrupt before return
// - Nesting mode saves and restores flag word
// - Higher priority normal interrupt may preempt
// - Fast on/off sets or clears enable
// - Mask set writes both enables at once
// - Segment field six bits, zero extended
// - Segment loads from six-bit immediate
// - No-operation only advances program counter
// - Flag word copied to register, and from register with bit 15 cleared
// - Shadow bank flag resets to zero
// - Fraction flag resets to zero
// - Result pair is R4 high, R3 low
`timescale 1ns/1ps
`default_nettype none
module flow_ctrl
   import flow_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // Instruction decode
   input  wire instr_t      instr_in,
   input  wire logic [3:0]  read_wait_in,
   input  wire logic [3:0]  write_wait_in,
   output logic             busy_out,
   // Interrupt sources
   input  wire irq_req_t    irq_in,
   output logic             fiq_taken_out,
   output logic [7:0]       irq_taken_out,
   // Stack memory port
   output logic             stack_push_out,
   output logic             stack_pop_out,
   output logic [15:0]      stack_wdata_out,
   input  wire logic [15:0] stack_rdata_in,
   // Core state
   output logic [21:0]      pc_out,
   output logic [15:0]      flag_word_out,
   output logic [15:0]      status_word_out,
   output logic             in_fiq_out,
   output logic             in_irq_out
);
   typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_POP, ST_WAIT} state_t;

   state_t      state, next_state;
   logic [15:0] processor_flag_word, next_flag;
   logic [15:0] status_word, next_status;
   logic [21:0] pc, next_pc;
   logic [7:0]  cnt, next_cnt;
   logic [2:0]  seq, next_seq;
   logic        in_fiq, next_in_fiq;
   logic        in_irq, next_in_irq;
   logic        push_q, next_push;
   logic        pop_q, next_pop;
   logic [15:0] pdata_q, next_pdata;
   logic        popping_reti, next_popping_reti;
   logic        fiq_tk, next_fiq_tk;
   logic [7:0]  irq_tk, next_irq_tk;
   logic        busy_q, next_busy;
   logic        rf_we;
   logic [15:0] rf_wdata;
   logic [15:0] rf_rdata;
   logic [15:0] r3;
   logic [15:0] r4;
   logic [3:0]  pri;
   logic [2:0]  irq_idx;
   logic        irq_any;
   logic [7:0]  irq_enabled;
   logic [2:0]  irq_idx_q;

   assign pri = processor_flag_word[PRI_HI:PRI_LO];

   // =====================================================================
   // Register file
   flow_regfile u_regfile (
      .clock_in  (clock_in),
      .srst_in   (srst_in),
      .bank_in   (processor_flag_word[BANK_BIT]),
      .we_in     (rf_we),
      .waddr_in  (instr_in.reg_sel),
      .wdata_in  (rf_wdata),
      .raddr_in  (instr_in.reg_sel),
      .rdata_out (rf_rdata),
      .r3_out    (r3),
      .r4_out    (r4)
   );

   // =====================================================================
   // Interrupt priority
   // Levels below field enabled
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_lvl
         assign irq_enabled[g] = irq_in.irq[g] && (4'(g) < pri);
      end
   endgenerate

   always_comb begin
      irq_idx = 3'd0;
      irq_any = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (irq_enabled[i]) begin
            irq_idx = 3'(i);
            irq_any = 1'b1;
         end
      end
   end

   // =====================================================================
   // Sequencer
   always_comb begin
      next_state        = state;
      next_flag         = processor_flag_word;
      next_status       = status_word;
      next_pc           = pc;
      next_cnt          = cnt;
      next_seq          = seq;
      next_in_fiq       = in_fiq;
      next_in_irq       = in_irq;
      next_push         = 1'b0;
      next_pop          = 1'b0;
      next_pdata        = pdata_q;
      next_popping_reti = popping_reti;
      next_fiq_tk       = 1'b0;
      next_irq_tk       = 8'h00;
      rf_we             = 1'b0;
      rf_wdata          = 16'h0000;
      case (state)
         ST_IDLE: begin
            if (irq_in.fiq && processor_flag_word[FIQEN_BIT] && !in_fiq) begin
               next_in_fiq = 1'b1;
               next_fiq_tk = 1'b1;
               next_pdata  = processor_flag_word;
               next_popping_reti = 1'b1;
               next_seq    = processor_flag_word[NEST_BIT] ? 3'd3 : 3'd2;
               next_state  = ST_PUSH;
               next_cnt    = CYC_BREAK + 8'(2 * read_wait_in) + 8'(2 * write_wait_in);
            end else if (irq_any && processor_flag_word[IRQEN_BIT] && !in_fiq &&
                         (!in_irq || processor_flag_word[NEST_BIT])) begin
               next_in_irq = 1'b1;
               next_irq_tk = 8'(1) << irq_idx;
               next_flag[PRI_HI:PRI_LO] = {1'b0, irq_idx};
               // Flag word saved before the level changes
               next_pdata  = processor_flag_word;
               next_popping_reti = 1'b1;
               next_seq    = processor_flag_word[NEST_BIT] ? 3'd3 : 3'd2;
               next_state  = ST_PUSH;
               next_cnt    = CYC_BREAK + 8'(2 * read_wait_in) + 8'(2 * write_wait_in);
            end else if (instr_in.valid) begin
               next_pc    = pc + 22'd1;
               next_cnt   = CYC_SHORT + 8'(read_wait_in);
               next_state = ST_WAIT;
               case (instr_in.op)
                  OP_JMPF: begin
                     next_pc  = instr_in.target;
                     next_cnt = CYC_JMPF + 8'(2 * read_wait_in);
                  end
                  OP_JMPR: begin
                     next_pc  = {r4[5:0], r3};
                     next_cnt = CYC_JMPR + 8'(read_wait_in);
                  end
                  OP_CALLR: begin
                     // Return address is pushed, target loaded after
                     next_popping_reti = 1'b0;
                     next_pdata = status_word;
                     next_seq   = 3'd2;
                     next_state = ST_PUSH;
                     next_cnt   = CYC_CALLR + 8'(read_wait_in) + 8'(2 * write_wait_in);
                  end
                  OP_RETF: begin
                     next_seq          = 3'd0;
                     next_popping_reti = 1'b0;
                     next_state        = ST_POP;
                     next_cnt          = CYC_RETF + 8'(3 * read_wait_in);
                  end
                  OP_RETI: begin
                     next_seq          = 3'd0;
                     next_popping_reti = 1'b1;
                     next_state        = ST_POP;
                     next_cnt          = processor_flag_word[NEST_BIT] ?
                        CYC_RETIN + 8'(4 * read_wait_in) : CYC_RETI + 8'(3 * read_wait_in);
                  end
                  OP_BREAK: begin
                     next_in_irq = 1'b1;
                     next_pdata  = processor_flag_word;
                     next_popping_reti = 1'b1;
                     next_seq    = processor_flag_word[NEST_BIT] ? 3'd3 : 3'd2;
                     next_state  = ST_PUSH;
                     next_cnt    = CYC_BREAK + 8'(2 * read_wait_in) + 8'(2 * write_wait_in);
                  end
                  OP_FIQ_ON:     next_flag[FIQEN_BIT] = 1'b1;
                  OP_FIQ_OFF:    next_flag[FIQEN_BIT] = 1'b0;
                  OP_IRQ_ON:     next_flag[IRQEN_BIT] = 1'b1;
                  OP_IRQ_OFF:    next_flag[IRQEN_BIT] = 1'b0;
                  OP_INT_FIQ:    next_flag[FIQEN_BIT:IRQEN_BIT] = 2'b10;
                  OP_INT_IRQ:    next_flag[FIQEN_BIT:IRQEN_BIT] = 2'b01;
                  OP_INT_BOTH:   next_flag[FIQEN_BIT:IRQEN_BIT] = 2'b11;
                  OP_INT_OFF:    next_flag[FIQEN_BIT:IRQEN_BIT] = 2'b00;
                  OP_BANK_ON:    next_flag[BANK_BIT] = 1'b1;
                  OP_BANK_OFF:   next_flag[BANK_BIT] = 1'b0;
                  OP_FRAC_ON:    next_flag[FRAC_BIT] = 1'b1;
                  OP_FRAC_OFF:   next_flag[FRAC_BIT] = 1'b0;
                  OP_NEST_ON:    next_flag[NEST_BIT] = 1'b1;
                  OP_NEST_OFF:   next_flag[NEST_BIT] = 1'b0;
                  OP_FIRMOV_ON:  next_flag[FIRMOV_BIT] = 1'b0;
                  OP_FIRMOV_OFF: next_flag[FIRMOV_BIT] = 1'b1;
                  OP_DS_SET:     next_status[15:10] = rf_rdata[5:0];
                  OP_DS_GET: begin
                     rf_we    = 1'b1;
                     rf_wdata = {10'h000, status_word[15:10]};
                  end
                  OP_DS_IMM:     next_status[15:10] = instr_in.imm6;
                  OP_FLAG_SET:   next_flag = {1'b0, rf_rdata[14:0]};
                  OP_FLAG_GET: begin
                     rf_we    = 1'b1;
                     rf_wdata = processor_flag_word;
                  end
                  default: ;
               endcase
            end
         end
         ST_PUSH: begin
            next_cnt  = cnt - 8'd1;
            next_push = 1'b1;
            case (seq)
               3'd3:    next_pdata = pdata_q;
               3'd2:    next_pdata = status_word;
               3'd1:    next_pdata = {10'h000, pc[21:16]};
               default: next_pdata = pc[15:0];
            endcase
            if (seq == 3'd0) begin
               next_state = ST_WAIT;
               if (popping_reti) begin
                  next_pc = BREAK_VEC;
               end else begin
                  next_pc = {r4[5:0], r3};
               end
            end
            next_seq = seq - 3'd1;
         end
         ST_POP: begin
            next_cnt = cnt - 8'd1;
            next_pop = 1'b1;
            case (seq)
               3'd3:    next_flag   = stack_rdata_in;
               3'd2:    next_status = stack_rdata_in;
               3'd1:    next_pc     = {stack_rdata_in[5:0], pc[15:0]};
               default: next_pc     = {pc[21:16], stack_rdata_in};
            endcase
            // Last pushed word comes back first
            if (seq == ((popping_reti && processor_flag_word[NEST_BIT]) ? 3'd3 : 3'd2)) begin
               next_state = ST_WAIT;
               if (popping_reti) begin
                  if (in_fiq) begin
                     next_in_fiq = 1'b0;
                  end else begin
                     next_in_irq = 1'b0;
                  end
               end
            end
            next_seq = seq + 3'd1;
         end
         ST_WAIT: begin
            next_cnt = cnt - 8'd1;
            if (cnt <= 8'd1) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_busy = (next_state != ST_IDLE);
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state               <= ST_IDLE;
         processor_flag_word <= FLAG_RESET;
         status_word         <= {DS_RESET, 10'h000};
         pc                  <= PC_RESET;
         cnt                 <= 8'h00;
         seq                 <= 3'd0;
         in_fiq              <= 1'b0;
         in_irq              <= 1'b0;
         push_q              <= 1'b0;
         pop_q               <= 1'b0;
         pdata_q             <= 16'h0000;
         popping_reti        <= 1'b0;
         fiq_tk              <= 1'b0;
         irq_tk              <= 8'h00;
         busy_q              <= 1'b0;
      end else begin
         state               <= next_state;
         processor_flag_word <= next_flag;
         status_word         <= next_status;
         pc                  <= next_pc;
         cnt                 <= next_cnt;
         seq                 <= next_seq;
         in_fiq              <= next_in_fiq;
         in_irq              <= next_in_irq;
         push_q              <= next_push;
         pop_q               <= next_pop;
         pdata_q             <= next_pdata;
         popping_reti        <= next_popping_reti;
         fiq_tk              <= next_fiq_tk;
         irq_tk              <= next_irq_tk;
         busy_q              <= next_busy;
      end
   end

   assign busy_out        = busy_q;
   assign stack_push_out  = push_q;
   assign stack_pop_out   = pop_q;
   assign stack_wdata_out = pdata_q;
   assign pc_out          = pc;
   assign flag_word_out   = processor_flag_word;
   assign status_word_out = status_word;
   assign in_fiq_out      = in_fiq;
   assign in_irq_out      = in_irq;
   assign fiq_taken_out   = fiq_tk;
   assign irq_taken_out   = irq_tk;

   // =====================================================================
   // Checks
   flag_reset_a: assert property (@(posedge clock_in)
      $past(srst_in) |-> processor_flag_word == FLAG_RESET)
      else $error("flag word not at reset value");
   fiq_block_a: assert property (@(posedge clock_in) disable iff (srst_in)
      $past(in_fiq) |-> !fiq_tk)
      else $error("fast interrupt taken while in service");
   jmpr_target_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (state == ST_IDLE && !fiq_tk && instr_in.valid && instr_in.op == OP_JMPR &&
       !(irq_in.fiq && processor_flag_word[FIQEN_BIT] && !in_fiq) && !irq_any)
      |=> pc == {$past(r4[5:0]), $past(r3)})
      else $error("indirect jump target wrong");
   int_both_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (state == ST_IDLE && instr_in.valid && instr_in.op == OP_INT_BOTH && !irq_any &&
       !irq_in.fiq) |=> processor_flag_word[FIQEN_BIT:IRQEN_BIT] == 2'b11)
      else $error("mask set did not enable both");
   ds_get_a: assert property (@(posedge clock_in) disable iff (srst_in)
      rf_we && instr_in.op == OP_DS_GET |-> rf_wdata[15:6] == 10'h000)
      else $error("segment read not zero extended");
   irq_level_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (|irq_tk) |-> $past(pri) > 4'(irq_idx_q))
      else $error("normal interrupt above level taken");
   nop_flags_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (state == ST_IDLE && instr_in.valid && instr_in.op == OP_NOP && !irq_any &&
       !irq_in.fiq) |=> $stable(processor_flag_word) && $stable(status_word))
      else $error("no-operation changed state");
   reti_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (state == ST_POP && next_state == ST_WAIT && popping_reti && in_fiq) |=> !in_fiq)
      else $error("fast service flag not cleared");

   always_ff @(posedge clock_in) begin
      irq_idx_q <= irq_idx;
   end
endmodule
`default_nettype wire

/* rtl/flow_regfile.sv */
// Eight-entry general register file with shadow bank and registered read
`timescale 1ns/1ps
`default_nettype none
module flow_regfile
   import flow_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // Shadow mapping
   input  wire logic        bank_in,
   // Write port
   input  wire logic        we_in,
   input  wire logic [2:0]  waddr_in,
   input  wire logic [15:0] wdata_in,
   // Read ports
   input  wire logic [2:0]  raddr_in,
   output logic      [15:0] rdata_out,
   output logic      [15:0] r3_out,
   output logic      [15:0] r4_out
);
   logic [15:0] main_q [8];
   logic [15:0] shadow_q [4];
   logic        is_gen_w;
   logic        is_gen_r;

   assign is_gen_w = (waddr_in >= REG_R1) && (waddr_in <= REG_R4);
   assign is_gen_r = (raddr_in >= REG_R1) && (raddr_in <= REG_R4);

   // =====================================================================
   // Storage
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rdata_out <= 16'h0000;
         r3_out    <= 16'h0000;
         r4_out    <= 16'h0000;
      end else begin
         if (we_in && bank_in && is_gen_w) begin
            shadow_q[waddr_in[1:0] - 2'd1] <= wdata_in;
         end else if (we_in) begin
            main_q[waddr_in] <= wdata_in;
         end
         rdata_out <= (bank_in && is_gen_r) ? shadow_q[raddr_in[1:0] - 2'd1]
                                            : main_q[raddr_in];
         r3_out <= bank_in ? shadow_q[2] : main_q[REG_R3];
         r4_out <= bank_in ? shadow_q[3] : main_q[REG_R4];
      end
   end
endmodule
`default_nettype wire

/* shared/flow_pkg.sv */
// Package: constants, types and encodings for the flow and mode control block
package flow_pkg;

   // Flag word field positions
   localparam int AQ_BIT      = 14;
   localparam int BANK_BIT    = 13;
   localparam int FRAC_BIT    = 12;
   localparam int FIRMOV_BIT  = 11;
   localparam int GUARD_HI    = 10;
   localparam int GUARD_LO    = 7;
   localparam int FIQEN_BIT   = 6;
   localparam int IRQEN_BIT   = 5;
   localparam int NEST_BIT    = 4;
   localparam int PRI_HI      = 3;
   localparam int PRI_LO      = 0;

   // Reset values
   localparam logic [15:0] FLAG_RESET = 16'h0008;
   localparam logic [5:0]  DS_RESET   = 6'h00;
   localparam logic [21:0] PC_RESET   = 22'h00_0000;
   localparam logic [15:0] SP_RESET   = 16'h0000;
   localparam logic [3:0]  PRI_ALL    = 4'h8;

   // Register file indices
   localparam logic [2:0] REG_SP = 3'h0;
   localparam logic [2:0] REG_R1 = 3'h1;
   localparam logic [2:0] REG_R3 = 3'h3;
   localparam logic [2:0] REG_R4 = 3'h4;
   localparam logic [2:0] REG_BP = 3'h5;
   localparam logic [2:0] REG_SR = 3'h6;
   localparam logic [2:0] REG_PC = 3'h7;

   // Base cycle counts, before read and write wait periods
   localparam logic [7:0] CYC_SHORT  = 8'h02;
   localparam logic [7:0] CYC_JMPF   = 8'h05;
   localparam logic [7:0] CYC_JMPR   = 8'h04;
   localparam logic [7:0] CYC_CALLR  = 8'h08;
   localparam logic [7:0] CYC_RETF   = 8'h08;
   localparam logic [7:0] CYC_RETI   = 8'h08;
   localparam logic [7:0] CYC_RETIN  = 8'h0A;
   localparam logic [7:0] CYC_BREAK  = 8'h0A;

   // Software interrupt vector
   localparam logic [21:0] BREAK_VEC = 22'h00_FFF5;

   typedef enum logic [4:0] {
      OP_NOP, OP_JMPF, OP_JMPR, OP_CALLR, OP_RETF, OP_RETI, OP_BREAK,
      OP_FIQ_ON, OP_FIQ_OFF, OP_IRQ_ON, OP_IRQ_OFF,
      OP_INT_FIQ, OP_INT_IRQ, OP_INT_BOTH, OP_INT_OFF,
      OP_BANK_ON, OP_BANK_OFF, OP_FRAC_ON, OP_FRAC_OFF,
      OP_NEST_ON, OP_NEST_OFF, OP_FIRMOV_ON, OP_FIRMOV_OFF,
      OP_DS_SET, OP_DS_GET, OP_DS_IMM, OP_FLAG_SET, OP_FLAG_GET
   } opcode_t;

   // Decoded request from instruction decode
   typedef struct packed {
      logic        valid;
      opcode_t     op;
      logic [2:0]  reg_sel;
      logic [5:0]  imm6;
      logic [21:0] target;
   } instr_t;

   // Interrupt request from the interrupt controller
   typedef struct packed {
      logic       fiq;
      logic [7:0] irq;
   } irq_req_t;

endpackage

/* test/cpu_flow_and_mode_instructions_bench.sv */
// Self-checking bench for the flow and mode control block
`timescale 1ns/1ps
`default_nettype none
module cpu_flow_and_mode_instructions_bench;
   import flow_pkg::*;
   localparam int RW = 1;
   localparam int SW = 2;
   logic        clock_in = 1'b0;
   logic        srst_in  = 1'b1;
   instr_t      instr    = '0;
   irq_req_t    irq      = '0;
   logic        busy;
   logic        fiq_tk;
   logic        push;
   logic        pop;
   logic        in_fiq;
   logic        in_irq;
   logic [7:0]  irq_tk;
   logic [7:0]  tk;
   logic [15:0] wdata;
   logic [15:0] flag;
   logic [15:0] stat;
   logic [15:0] ef;
   logic [21:0] pc;
   logic [15:0] mem [0:63];
   int          sp = 0;
   int          pushes = 0;
   int          pops = 0;
   int          nb;
   int          seen;
   int          cyc = 0;
   int          miscompares = 0;
   int          compares = 0;
   opcode_t     ops [11];
   logic [15:0] msk [11];
   logic [15:0] val [11];
   // Stack memory runs one word ahead while a pop burst is under way
   wire  logic [15:0] rdata = pop ? mem[(sp - 2) & 63] : mem[(sp - 1) & 63];

   flow_ctrl dut (.clock_in(clock_in), .srst_in(srst_in), .instr_in(instr),
      .read_wait_in(4'(RW)), .write_wait_in(4'(SW)), .busy_out(busy), .irq_in(irq),
      .fiq_taken_out(fiq_tk), .irq_taken_out(irq_tk), .stack_push_out(push),
      .stack_pop_out(pop), .stack_wdata_out(wdata), .stack_rdata_in(rdata), .pc_out(pc),
      .flag_word_out(flag), .status_word_out(stat), .in_fiq_out(in_fiq), .in_irq_out(in_irq));

   always #12.5 clock_in = ~clock_in;

   // ==========================================
   // Stack model and run limit
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (push === 1'b1) begin
         mem[sp & 63] <= wdata;
         sp <= sp + 1;
         pushes <= pushes + 1;
      end
      if (pop === 1'b1) begin
         sp <= sp - 1;
         pops <= pops + 1;
      end
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   // ==========================================
   // Tasks
   task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_n(input string n, input int e, input int g);
      compares++;
      if (g != e) begin
         miscompares++;
         $display("[ERR] %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic exec(input opcode_t op, input logic [2:0] rs, input logic [5:0] im,
                       input logic [21:0] tg);
      @(negedge clock_in);
      while (busy !== 1'b0) @(negedge clock_in);
      pushes = 0;
      pops = 0;
      // Register operand is read a cycle ahead
      @(posedge clock_in);
      instr.reg_sel <= rs;
      @(posedge clock_in);
      instr <= '{1'b1, op, rs, im, tg};
      @(posedge clock_in);
      instr.valid <= 1'b0;
      nb = 0;
      @(negedge clock_in);
      while (busy === 1'b1 && nb < 400) begin
         nb++;
         @(negedge clock_in);
      end
   endtask

   // Holds a request level for a while and notes whether it was accepted
   task automatic intr(input logic f, input logic [7:0] l);
      seen = 0;
      tk = 8'h00;
      pushes = 0;
      @(posedge clock_in);
      irq <= '{f, l};
      repeat (30) begin
         @(negedge clock_in);
         if (fiq_tk === 1'b1 || irq_tk !== 8'h00) begin
            seen = 1;
            tk = irq_tk;
         end
      end
      @(posedge clock_in);
      irq <= '0;
   endtask

   task automatic end_sim();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================
   // Test sequence
   initial begin
      ops = '{OP_FIQ_ON, OP_IRQ_ON, OP_FIQ_OFF, OP_IRQ_OFF, OP_INT_FIQ, OP_INT_IRQ,
              OP_INT_BOTH, OP_INT_OFF, OP_NEST_ON, OP_NEST_OFF, OP_FRAC_ON};
      msk = '{16'h0040, 16'h0020, 16'h0040, 16'h0020, 16'h0060, 16'h0060, 16'h0060,
              16'h0060, 16'h0010, 16'h0010, 16'h1000};
      val = '{16'h0040, 16'h0020, 16'h0000, 16'h0000, 16'h0040, 16'h0020, 16'h0060,
              16'h0000, 16'h0010, 16'h0000, 16'h1000};
      repeat (5) @(posedge clock_in);
      srst_in <= 1'b0;
      @(negedge clock_in);
      ef = 16'h0008;
      chk("flag reset", 22'(ef), 22'(flag));
      for (int i = 0; i < 11; i++) begin
         exec(ops[i], REG_R1, 6'h00, 22'h00_0000);
         ef = (ef & ~msk[i]) | val[i];
         chk("mode flag", 22'(ef), 22'(flag));
         chk_n("mode cycles", 2 + RW, nb);
      end
      exec(OP_JMPF, REG_R1, 6'h00, 22'h3A_BCDE);
      chk("far jump pc", 22'h3A_BCDE, pc);
      chk_n("far jump cycles", 5 + 2 * RW, nb);
      exec(OP_NOP, REG_R1, 6'h00, 22'h00_0000);
      chk("nop pc", 22'h3A_BCDF, pc);
      chk("nop flag", 22'(ef), 22'(flag));
      exec(OP_FLAG_GET, REG_R4, 6'h00, 22'h00_0000);
      exec(OP_DS_IMM, REG_R1, 6'h3F, 22'h00_0000);
      chk("segment imm", 22'h00_003F, 22'(stat[15:10]));
      exec(OP_DS_GET, REG_R3, 6'h00, 22'h00_0000);
      exec(OP_JMPR, REG_R1, 6'h00, 22'h00_0000);
      chk("pair jump pc", 22'h08_003F, pc);
      chk_n("pair jump cycles", 4 + RW, nb);
      exec(OP_DS_SET, REG_R4, 6'h00, 22'h00_0000);
      chk("segment from reg", 22'h00_0008, 22'(stat[15:10]));
      exec(OP_FLAG_SET, REG_R3, 6'h00, 22'h00_0000);
      ef = 16'h003F;
      chk("flag load", 22'(ef), 22'(flag));
      exec(OP_BANK_ON, REG_R1, 6'h00, 22'h00_0000);
      chk("bank flag", 22'h00_203F, 22'(flag));
      exec(OP_FLAG_GET, REG_R3, 6'h00, 22'h00_0000);
      exec(OP_BANK_OFF, REG_R1, 6'h00, 22'h00_0000);
      exec(OP_JMPR, REG_R1, 6'h00, 22'h00_0000);
      chk("shadow kept apart", 22'h08_003F, pc);
      exec(OP_JMPF, REG_R1, 6'h00, 22'h01_2340);
      exec(OP_CALLR, REG_R1, 6'h00, 22'h00_0000);
      chk("call pc", 22'h08_003F, pc);
      chk_n("call pushes", 3, pushes);
      chk_n("call cycles", 8 + RW + 2 * SW, nb);
      exec(OP_DS_IMM, REG_R1, 6'h2A, 22'h00_0000);
      exec(OP_RETF, REG_R1, 6'h00, 22'h00_0000);
      chk_n("return pops", 3, pops);
      chk("return pc", 22'h01_2341, pc);
      chk("return segment", 22'h00_0008, 22'(stat[15:10]));
      exec(OP_NEST_OFF, REG_R1, 6'h00, 22'h00_0000);
      exec(OP_JMPF, REG_R1, 6'h00, 22'h02_0000);
      exec(OP_BREAK, REG_R1, 6'h00, 22'h00_0000);
      chk("break pc", BREAK_VEC, pc);
      chk_n("break pushes", 3, pushes);
      chk_n("break cycles", 10 + 2 * RW + 2 * SW, nb);
      exec(OP_DS_IMM, REG_R1, 6'h15, 22'h00_0000);
      exec(OP_RETI, REG_R1, 6'h00, 22'h00_0000);
      chk_n("iret pops", 3, pops);
      chk_n("iret cycles", 8 + 3 * RW, nb);
      chk("iret pc", 22'h02_0001, pc);
      chk("iret segment", 22'h00_0008, 22'(stat[15:10]));
      exec(OP_NEST_ON, REG_R1, 6'h00, 22'h00_0000);
      intr(1'b0, 8'h08);
      chk_n("level three taken", 1, seen);
      chk("taken vector", 22'h00_0008, 22'(tk));
      chk_n("nested pushes", 4, pushes);
      chk("in service", 22'h00_0001, 22'(in_irq));
      chk("level set", 22'h00_0003, 22'(flag[3:0]));
      intr(1'b0, 8'h20);
      chk_n("lower level held", 0, seen);
      intr(1'b0, 8'h02);
      chk_n("higher level preempts", 1, seen);
      chk("preempt vector", 22'h00_0002, 22'(tk));
      exec(OP_RETI, REG_R1, 6'h00, 22'h00_0000);
      chk_n("nested iret pops", 4, pops);
      chk_n("nested iret cycles", 10 + 4 * RW, nb);
      exec(OP_RETI, REG_R1, 6'h00, 22'h00_0000);
      chk("service cleared", 22'h00_0000, 22'(in_irq));
      exec(OP_INT_FIQ, REG_R1, 6'h00, 22'h00_0000);
      intr(1'b1, 8'h00);
      chk_n("fast taken", 1, seen);
      chk("fast service", 22'h00_0001, 22'(in_fiq));
      intr(1'b1, 8'h00);
      chk_n("second fast held", 0, seen);
      exec(OP_RETI, REG_R1, 6'h00, 22'h00_0000);
      chk("fast cleared", 22'h00_0000, 22'(in_fiq));
      end_sim();
   end
endmodule
`default_nettype wire
